// [rtl/log_page_params.svh]
`ifndef LOG_PAGE_PARAMS_SVH
`define LOG_PAGE_PARAMS_SVH
// wishbone register byte offsets
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_DATA        8'h08
`define REG_ERR0        8'h0c
`define REG_ERR1        8'h10
`define REG_ERR2        8'h14
`define REG_ERR3        8'h18
`define REG_CAP_LO      8'h1c
`define REG_CAP_HI      8'h20
`define REG_SECT_LO     8'h24
`define REG_SECT_HI     8'h28
`define REG_LSIZE       8'h2c
`define REG_BUF_LO      8'h30
`define REG_BUF_HI      8'h34
`define REG_FLAGS       8'h38
`define REG_IDW         8'h3c
`define REG_IDENT       8'h40
// control fields
`define CTRL_START_BIT  8
`define CTRL_PAGE_LSB   0
// page numbers, page revision and page layout constants
`define PG_LIST         8'h00
`define PG_IDENT        8'h01
`define PG_CAP          8'h02
`define PG_QERR         8'h10
`define PG_REV          16'h0001
`define PG_BYTES        10'd512
`define LIST_COUNT      8'h03
`define LAST_BYTE       9'h1ff
// queued error byte 0 fields and last snapshot byte index
`define NQ_BIT          7
`define UNLOAD_BIT      6
`define QERR_LAST_SNAP  9'd13
`endif

// [rtl/log_page_pkg.sv]
package log_page_pkg;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_STREAM,
      ST_DONE
   } stream_state_t;
   typedef logic [7:0] byte_t;
endpackage

// [rtl/ident_store.sv]
`timescale 1ns/10ps
`default_nettype none
module ident_store
   import log_page_pkg::*;
#(
   parameter int WORDS = 256
) (
   input  wire logic                     clk_i,
   // firmware load port
   input  wire logic                     we_i,
   input  wire logic [$clog2(WORDS)-1:0] waddr_i,
   input  wire logic [15:0]              wdata_i,
   // page read port
   input  wire logic [$clog2(WORDS)-1:0] raddr_i,
   output logic      [15:0]              rdata_o
);
   logic [15:0] mem [WORDS];

   // written only by the firmware load port; no path from the log read side
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end
endmodule
`default_nettype wire

// [rtl/device_log_page_builder.sv]
// Chosen here: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "log_page_params.svh"
module device_log_page_builder
   import log_page_pkg::*;
#(
   parameter int ID_WORDS = 256
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o
);
   typedef struct packed {
      stream_state_t st;
      logic [7:0]    page;
      logic [9:0]    idx;
      logic [7:0]    sum;
      logic          bad;
      logic          dvalid;
      logic [7:0]    dbyte;
      logic          ack;
      logic [31:0]   rdat;
      logic [31:0]   err0;
      logic [31:0]   err1;
      logic [31:0]   err2;
      logic [31:0]   err3;
      logic [63:0]   cap;
      logic [63:0]   sect;
      logic [31:0]   lsize;
      logic [63:0]   bufsz;
      logic [3:0]    flags;
      logic [7:0]    idw_addr;
      logic [15:0]   idw_data;
      logic          idw_we;
   } state_t;

   state_t q, d;
   logic [15:0] id_rdata;
   logic        wr_acc;
   logic        rd_acc;
   logic [7:0]  b;
   logic [7:0]  qb;
   logic [8:0]  pos;
   logic        page_ok;
   logic [63:0] hdr_qw;
   logic [63:0] cap_qw;
   logic [63:0] sect_qw;
   logic [63:0] lsize_qw;
   logic [63:0] buf_qw;
   logic [63:0] cap_sel;

   // =========================================================
   // identity store, addressed one index ahead so its registered read meets pos
   // =========================================================
   ident_store #(
      .WORDS (ID_WORDS)
   ) u_ident (
      .clk_i   (clk_i),
      .we_i    (q.idw_we),
      .waddr_i (q.idw_addr),
      .wdata_i (q.idw_data),
      .raddr_i (d.idx[8:1]),
      .rdata_o (id_rdata)
   );

   // =========================================================
   // bus acceptance and stream position
   // =========================================================
   // a request is taken once; the pending ack blocks a second take
   assign wr_acc = cyc_i && stb_i && we_i && !q.ack;
   assign rd_acc = cyc_i && stb_i && !we_i && !q.ack;
   assign pos    = q.idx[8:0];
   // only pages with content behind them may start a stream
   assign page_ok = (dat_i[7:0] == `PG_LIST) || (dat_i[7:0] == `PG_IDENT) ||
                    (dat_i[7:0] == `PG_CAP)  || (dat_i[7:0] == `PG_QERR);

   // =========================================================
   // byte generator for the current stream position
   // =========================================================
   always_comb begin
      b  = 8'h00;
      qb = 8'h00;
      // error log snapshot: err0..err3 hold bytes 0..13 little endian
      case (pos)
         9'd0:  qb = q.err0[7] ? {1'b1, q.err0[6], 6'h00}
                               : {1'b0, q.err0[6], 1'b0, q.err0[4:0]};
         9'd1:  qb = q.err0[15:8];
         9'd2:  qb = q.err0[23:16];
         9'd3:  qb = q.err0[31:24];
         9'd4:  qb = q.err1[7:0];
         9'd5:  qb = q.err1[15:8];
         9'd6:  qb = q.err1[23:16];
         9'd7:  qb = q.err1[31:24];
         9'd8:  qb = q.err2[7:0];
         9'd9:  qb = q.err2[15:8];
         9'd10: qb = q.err2[23:16];
         9'd11: qb = q.err2[31:24];
         9'd12: qb = q.err3[7:0];
         9'd13: qb = q.err3[15:8];
         default: qb = 8'h00;
      endcase
      case (q.page)
         `PG_QERR: begin
            b = (pos == `LAST_BYTE) ? (8'h00 - q.sum) : qb;
         end
         `PG_LIST: begin
            case (pos)
               9'd0:  b = 8'(`PG_REV);
               9'd1:  b = 8'h00;
               9'd2:  b = `PG_LIST;
               9'd8:  b = `LIST_COUNT;
               9'd9:  b = `PG_LIST;
               9'd10: b = `PG_IDENT;
               9'd11: b = `PG_CAP;
               default: b = 8'h00;
            endcase
         end
         `PG_IDENT: begin
            b = pos[0] ? id_rdata[15:8] : id_rdata[7:0];
         end
         `PG_CAP: begin
            b = cap_sel[{pos[2:0], 3'b000} +: 8];
         end
         default: b = 8'h00;
      endcase
   end

   // =========================================================
   // capacity page qwords
   // =========================================================
   always_comb begin
      hdr_qw         = 64'h0;
      hdr_qw[63]     = 1'b1;
      hdr_qw[23:16]  = `PG_CAP;
      hdr_qw[15:0]   = `PG_REV;
      cap_qw         = 64'h0;
      cap_qw[63]     = 1'b1;
      cap_qw[47:0]   = q.cap[47:0];
      sect_qw        = 64'h0;
      sect_qw[63]    = q.flags[0];
      sect_qw[62]    = q.flags[1];              // relationship supported
      sect_qw[61]    = q.flags[2];              // logical size supported
      sect_qw[21:20] = q.sect[21:20];           // alignment error reporting
      sect_qw[19:16] = q.sect[19:16];           // logical to physical relationship
      sect_qw[15:0]  = q.sect[15:0];            // logical sector offset
      lsize_qw       = 64'h0;
      lsize_qw[63]   = q.flags[3];
      lsize_qw[31:0] = q.lsize;
      buf_qw         = q.bufsz;
      // pick the qword that holds the current byte
      case (pos[8:3])
         6'd0:    cap_sel = hdr_qw;
         6'd1:    cap_sel = cap_qw;
         6'd2:    cap_sel = sect_qw;
         6'd3:    cap_sel = lsize_qw;
         6'd4:    cap_sel = buf_qw;
         default: cap_sel = 64'h0;
      endcase
   end

   // =========================================================
   // stream control and register file
   // =========================================================
   always_comb begin
      d        = q;
      d.ack    = 1'b0;
      d.idw_we = 1'b0;
      // one byte is held at a time; the next is fetched once the host consumed it
      case (q.st)
         ST_IDLE: begin
            d.dvalid = 1'b0;
         end
         ST_DONE: begin
            // a finished or refused page holds no byte
            d.dvalid = 1'b0;
         end
         ST_STREAM: begin
            if (!q.dvalid) begin
               // all 512 bytes handed over: the page is finished
               if (q.idx == `PG_BYTES) begin
                  d.st = ST_DONE;
               end else begin
                  d.dvalid = 1'b1;
                  d.dbyte  = b;
                  d.sum    = q.sum + b;
                  d.idx    = q.idx + 10'd1;
               end
            end
         end
         default: begin
            d.st = ST_IDLE;
         end
      endcase
      if (wr_acc) begin
         d.ack = 1'b1;
         case (adr_i)
            `REG_CTRL: if (sel_i[1] && dat_i[`CTRL_START_BIT]) begin
               d.page   = dat_i[7:0];
               d.idx    = 10'd0;
               d.sum    = 8'h00;
               d.dvalid = 1'b0;
               d.bad    = !page_ok;
               d.st     = d.bad ? ST_DONE : ST_STREAM;
            end
            `REG_ERR0:    d.err0 = dat_i;
            `REG_ERR1:    d.err1 = dat_i;
            `REG_ERR2:    d.err2 = dat_i;
            `REG_ERR3:    d.err3 = dat_i;
            `REG_CAP_LO:  d.cap[31:0] = dat_i;
            `REG_CAP_HI:  d.cap[63:32] = dat_i;
            `REG_SECT_LO: d.sect[31:0] = dat_i;
            `REG_SECT_HI: d.sect[63:32] = dat_i;
            `REG_LSIZE:   d.lsize = dat_i;
            `REG_BUF_LO:  d.bufsz[31:0] = dat_i;
            `REG_BUF_HI:  d.bufsz[63:32] = dat_i;
            `REG_FLAGS:   d.flags = dat_i[3:0];
            `REG_IDW: begin
               // firmware load only; the stream path has no write access
               d.idw_addr = dat_i[23:16];
               d.idw_data = dat_i[15:0];
               d.idw_we   = 1'b1;
            end
            default: ;
         endcase
      end
      if (rd_acc) begin
         d.ack = 1'b1;
         case (adr_i)
            `REG_CTRL:   d.rdat = {23'h0, q.st == ST_STREAM, q.page};
            `REG_STATUS: d.rdat = {12'h0, q.idx, 6'h0, q.dvalid, q.bad,
                                   q.st == ST_DONE, q.st == ST_STREAM};
            `REG_DATA: begin
               d.rdat = {14'h0, q.idx, q.dbyte};
               if (q.dvalid) begin
                  d.dvalid = 1'b0;
               end
            end
            `REG_ERR0:   d.rdat = q.err0;
            `REG_ERR1:   d.rdat = q.err1;
            `REG_ERR2:   d.rdat = q.err2;
            `REG_ERR3:   d.rdat = q.err3;
            `REG_CAP_LO: d.rdat = q.cap[31:0];
            `REG_CAP_HI: d.rdat = q.cap[63:32];
            `REG_SECT_LO: d.rdat = q.sect[31:0];
            `REG_SECT_HI: d.rdat = q.sect[63:32];
            `REG_LSIZE:  d.rdat = q.lsize;
            `REG_BUF_LO: d.rdat = q.bufsz[31:0];
            `REG_BUF_HI: d.rdat = q.bufsz[63:32];
            `REG_IDW:    d.rdat = {8'h0, q.idw_addr, q.idw_data};
            `REG_FLAGS:  d.rdat = {28'h0, q.flags};
            `REG_IDENT:  d.rdat = {16'h0, id_rdata};
            default:     d.rdat = 32'h0000_0000;
         endcase
      end
   end

   // =========================================================
   // state register
   // =========================================================
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q       <= '0;
         q.st    <= ST_IDLE;
         q.bufsz <= 64'h0;
      end else begin
         q <= d;
      end
   end


   // =========================================================
   // outputs
   // =========================================================
   assign dat_o = q.rdat;
   assign ack_o = q.ack;
endmodule
`default_nettype wire

// [verif/device_log_page_builder_sva.sv]
`timescale 1ns/10ps
`default_nettype none
`include "log_page_params.svh"
module device_log_page_builder_sva (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o
);
   // ==========
   // bus and status checks
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire logic rd_sts = ack_o && !we_i && adr_i == `REG_STATUS;
   property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack late");
   property p_ack_pulse; ack_o |=> !ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
   property p_ack_cause; ack_o |-> $past(cyc_i && stb_i && !ack_o); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
   property p_dat_hold; $changed(dat_o) |-> ack_o && !we_i; endproperty
   a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
   property p_unmapped; cyc_i && stb_i && !ack_o && !we_i && adr_i > 8'h43 |=> dat_o == 0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
   property p_bad_done; rd_sts && dat_o[2] |-> dat_o[1]; endproperty
   a_bad_done: assert property (p_bad_done) else $error("bad not done");
   property p_bad_empty; rd_sts && dat_o[2] |-> !dat_o[3]; endproperty
   a_bad_empty: assert property (p_bad_empty) else $error("bad page data");
   property p_idx; ack_o && !we_i && adr_i == `REG_DATA |-> dat_o[17:8] inside {[1:512]}; endproperty
   a_idx: assert property (p_idx) else $error("index range");
endmodule
bind device_log_page_builder device_log_page_builder_sva i_sva (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o));
`default_nettype wire

// [verif/log_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module log_host_model (
   input  wire logic        clk_i,
   input  wire logic        ack_i,
   input  wire logic [31:0] dat_i,
   output logic             cyc_o,
   output logic             we_o,
   output logic [3:0]       sel_o,
   output logic [7:0]       adr_o,
   output logic [31:0]      dat_o
);
   // ==========
   // classic single cycle, entered just after a rising edge
   initial begin
      cyc_o = 1'b0;
      we_o = 1'b0;
      sel_o = 4'hf;
      adr_o = 8'h00;
      dat_o = 32'h0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
      cyc_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      dat_o <= d;
      @(posedge clk_i);
      while (ack_i !== 1'b1)
         @(posedge clk_i);
      r = dat_i;
      cyc_o <= 1'b0;
      we_o <= 1'b0;
      adr_o <= ~a;
      dat_o <= ~d;
      @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// [verif/device_log_page_builder_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "log_page_params.svh"
module device_log_page_builder_tb_top;
   logic        clk_i, rst_i, cyc, we, ack;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, q, c, lfsr_q;
   logic [31:0] msk[4] = '{32'hffff_005f, 32'hffff_ffff, 32'h00ff_ffff, 32'h0000_ffff};
   logic [15:0] idw[256];
   int          n_mismatch, num_checks, bsum, exp_b[512];
   // ==========
   // design, host and helpers
   device_log_page_builder i_device_log_page_builder (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc), .stb_i(cyc), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
      .dat_o(rdat), .ack_o(ack));
   log_host_model i_log_host_model (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat),
      .cyc_o(cyc), .we_o(we), .sel_o(sel), .adr_o(adr), .dat_o(wdat));
   function automatic logic [31:0] rnd();
      lfsr_q = {lfsr_q[30:0], ^(lfsr_q & 32'h8020_0003)};
      return lfsr_q;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_log_host_model.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a);
      i_log_host_model.xfer(1'b0, a, 32'h0, q);
   endtask
   // -1 in exp_b marks a byte with no defined value
   task automatic run_page(input logic [7:0] pg);
      bsum = 0;
      wr(`REG_CTRL, 32'h100 | 32'(pg));
      for (int i = 0; i < 512; i++) begin
         q = 0;
         while (q[3] !== 1'b1)
            rd(`REG_STATUS);
         rd(`REG_DATA);
         chk(32'(q[17:8]), 32'(i + 1));
         if (exp_b[i] >= 0)
            chk(32'(q[7:0]), 32'(exp_b[i]));
         bsum += q[7:0];
      end
      rd(`REG_STATUS);
      chk(32'(q[3:1]), 32'h1);
   endtask
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   initial begin
      repeat (90000) @(posedge clk_i);
      n_mismatch++;
      give_verdict();
   end
   initial begin
      rst_i = 1'b1;
      lfsr_q = 32'h276ab657;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(8'h80);
      chk(q, 32'h0);
      for (int w = 0; w < 256; w++) begin
         idw[w] = rnd();
         wr(`REG_IDW, {8'h0, 8'(w), idw[w]});
      end
      exp_b = '{default: 0};
      exp_b[0] = 1;
      exp_b[8] = 3;
      exp_b[10] = 1;
      exp_b[11] = 2;
      run_page(`PG_LIST);
      wr(`REG_DATA, 32'hffff_ffff);
      for (int i = 0; i < 512; i++)
         exp_b[i] = idw[i/2][8*(i%2)+:8];
      run_page(`PG_IDENT);
      c = rnd();
      wr(`REG_CAP_LO, c);
      wr(`REG_CAP_HI, c & 32'hffff);
      wr(`REG_FLAGS, 32'hf);
      exp_b = '{default: 0};
      for (int i = 0; i < 6; i++)
         exp_b[8+i] = c[8*(i%4)+:8];
      c = rnd();
      wr(`REG_LSIZE, c);
      for (int i = 0; i < 8; i++)
         exp_b[24+i] = (i < 4) ? c[8*i+:8] : 0;
      c = rnd();
      wr(`REG_SECT_LO, c);
      wr(`REG_BUF_LO, c);
      wr(`REG_BUF_HI, 32'h8000_0000);
      for (int i = 0; i < 4; i++)
         exp_b[32+i] = c[8*i+:8];
      exp_b[16] = c[7:0];
      exp_b[17] = c[15:8];
      exp_b[18] = c[21:16];
      exp_b[23] = 8'he0;
      exp_b[39] = 8'h80;
      exp_b[0] = 1;
      exp_b[2] = 2;
      exp_b[7] = 8'h80;
      exp_b[15] = 8'h80;
      exp_b[31] = 8'h80;
      run_page(`PG_CAP);
      for (int k = 0; k < 2; k++) begin
         exp_b = '{default: -1};
         for (int i = 23; i < 256; i++)
            exp_b[i] = 0;
         for (int r = 0; r < 4; r++) begin
            c = (rnd() & msk[r]) | ((r == 0 && k == 1) ? 32'h80 : 32'h0);
            wr(8'h0c + 8'(4 * r), c);
            for (int i = 0; i < 4; i++)
               if (4 * r + i < 14)
                  exp_b[4*r+i] = c[8*i+:8] & ((4 * r + i == 0 && k == 1) ? 8'hc0 : 8'hff);
         end
         run_page(`PG_QERR);
         chk(32'(bsum[7:0]), 32'h0);
      end
      for (int p = 3; p < 12; p += 6) begin
         wr(`REG_CTRL, 32'h100 | p);
         q = 0;
         while (q[1] !== 1'b1)
            rd(`REG_STATUS);
         chk(32'(q[3:2]), 32'h1);
      end
      give_verdict();
   end
endmodule
`default_nettype wire
